// >>> hw/rsis_pkg.sv
package rsis_pkg;
  // -------------------------------------------------------------------
  // Register offsets (printed offsets are not multiples of four, so
  // they are indices and the byte address is four times the index)
  // -------------------------------------------------------------------
  localparam logic [7:0] IDX_ROUTE = 8'h1f;
  localparam logic [7:0] IDX_FLAGS = 8'h20;
  localparam logic [7:0] IDX_MASK = 8'h21;
  localparam logic [7:0] IDX_TRIG_HI = 8'h22;
  localparam logic [7:0] IDX_TRIG_LO = 8'h23;
  localparam logic [7:0] IDX_BUF_CTRL = 8'h24;
  localparam logic [7:0] IDX_RX_STATUS = 8'h25;
  localparam logic [7:0] IDX_RX_ERR = 8'h26;
  localparam logic [7:0] IDX_ERR_MASK = 8'h27;
  localparam logic [7:0] IDX_PIN_CTRL = 8'h30;
  localparam int ADDR_W = 10;

  // -------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------
  localparam int POS_RXERR = 0;
  localparam int POS_OVF = 1;
  localparam int POS_USER = 3;
  localparam int POS_CSTAT = 4;
  localparam int POS_SUBQ = 5;
  localparam int POS_LOCK = 7;
  localparam logic [7:0] SRC_VALID = 8'hbb;
  localparam int POS_RECV_SEL = 0;
  localparam int POS_PASS_SEL = 4;
  localparam int POS_CHSEL = 0;
  localparam int POS_ACCESS = 1;
  localparam int POS_BUFSEL = 2;
  localparam int POS_LOCKMODE = 6;
  localparam logic [7:0] ERR_VALID = 8'h7f;

  // -------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_TRIG = 8'h00;
  localparam logic [7:0] RST_BUF_CTRL = 8'h40;
  localparam logic [7:0] RST_ERR_MASK = 8'h00;
  localparam logic [1:0] RST_PIN_POL = 2'h0;

  // -------------------------------------------------------------------
  // Codes
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    TRIG_RISE = 2'h0,
    TRIG_FALL = 2'h1,
    TRIG_LEVEL = 2'h2,
    TRIG_RSVD = 2'h3
  } rsis_trig_type;

  localparam logic [1:0] POL_HIGH = 2'h0;
  localparam logic [1:0] POL_LOW = 2'h1;
  localparam logic [1:0] POL_OPEN = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// >>> hw/rsis_top.sv
// Summary of operation
// RULE1 - Pass-through selector routes input n to pass-through pin; resets to zero.
// RULE2 - Receive selector routes input n to internal receiver; resets to zero.
// RULE3 - A status flag reads 1 if its event occurred since the last read.
// RULE4 - Reading the status register clears all its flags.
// RULE5 - Flags of disabled sources always read zero.
// RULE6 - Loss of receiver lock sets the lock-loss flag.
// RULE7 - A new changed subcode block sets the subcode flag.
// RULE8 - A channel-status buffer change sets the status transfer flag.
// RULE9 - A user-data buffer change sets the user transfer flag.
// RULE10 - A converter over-range anywhere sets the overflow flag.
// RULE11 - A receiver error sets the error flag; the cause sits in an error register.
// RULE12 - Mask bit 1 lets a source reach pin and status; 0 blocks; reset zero.
// RULE13 - Mask bits sit at the same positions as their status flags.
// RULE14 - Each source has a 2-bit trigger code from the high and low registers.
// RULE15 - Code 00 rising, 01 falling, 10 level; 11 reserved.
// RULE16 - Pin active level depends only on the pin polarity setting.
// RULE17 - Lock-mode bit: 1 (reset) newer mode, 0 compatibility mode.
// RULE18 - Buffer-select bit: 0 (reset) channel status, 1 user data.
// RULE19 - Access-mode bit: 0 (reset) one-byte, 1 two-byte mode.
// RULE20 - Channel-select bit picks channel A or B for status register.
// RULE21 - Read-only 4-bit auxiliary width field reports received aux width.
// RULE22 - Read-only format bit reports block format of selected channel.
// RULE23 - Pin polarity: 00 high, 01 low, 10 open-drain low; 11 reserved.
// RULE24 - Each error type reaches error register and flag only when unmasked.
// RULE25 - An event in the same cycle as the read-clear keeps its flag set.
//
// The implementer's own choice: the AXI4-Lite register port.
module rsis_top #(
  parameter int NUM_INPUTS = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // AXI4-Lite write address
  input wire logic [rsis_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read address
  input wire logic [rsis_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Audio inputs and routing
  input wire logic [NUM_INPUTS-1:0] receiver_input_in,
  output logic passthru_out,
  output logic receiver_feed_out,
  // Event sources from the receiver and converter
  input wire logic lock_lost_in,
  input wire logic subcode_new_in,
  input wire logic status_buf_changed_in,
  input wire logic user_buf_changed_in,
  input wire logic overrange_in,
  input wire logic [6:0] rx_error_cause_in,
  // Received channel status, channel A and B
  input wire logic [3:0] aux_width_a_in,
  input wire logic [3:0] aux_width_b_in,
  input wire logic [2:0] cstat_bits_a_in,
  input wire logic [2:0] cstat_bits_b_in,
  // Configuration to the receiver
  output logic lock_mode_out,
  output logic buffer_select_out,
  output logic buffer_access_mode_out,
  output logic channel_select_out,
  // Interrupt pin
  output logic irq_pin_o_out,
  output logic irq_pin_oe_n_out
);
  import rsis_pkg::*;

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] route;
    logic [7:0] flags;
    logic [7:0] mask;
    logic [7:0] trig_hi;
    logic [7:0] trig_lo;
    logic [7:0] buf_ctrl;
    logic [7:0] err_reg;
    logic [7:0] err_mask;
    logic [1:0] pin_pol;
    logic [7:0] cond_prev;
    logic [7:0] pend;
    logic pass;
    logic feed;
    logic irq_o;
    logic irq_oe_n;
  } rsis_state_type;

  rsis_state_type state_ff;
  rsis_state_type nxt_state;

  // Register index from a byte address; misaligned gives no match
  function automatic logic [7:0] reg_index(
    input logic [ADDR_W-1:0] addr
  );
    reg_index = (addr[1:0] == 2'h0) ? addr[ADDR_W-1:2] : 8'hff;
  endfunction

  // Trigger code per source
  function automatic rsis_trig_type trig_code(
    input logic [7:0] hi,
    input logic [7:0] lo,
    input int pos
  );
    trig_code = rsis_trig_type'({hi[pos], lo[pos]}); // RULE14
  endfunction

  // -------------------------------------------------------------------
  // Combinational helpers
  // -------------------------------------------------------------------
  logic [7:0] cond_now;
  logic [7:0] err_now;
  logic [7:0] event_hit;
  logic [7:0] rx_status_view;
  logic do_write;
  logic do_read;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [7:0] wr_byte;
  logic irq_active;

  always_comb begin
    err_now = {1'b0, rx_error_cause_in} & state_ff.err_mask; // RULE24
    cond_now = 8'h00;
    cond_now[POS_LOCK] = lock_lost_in; // RULE6
    cond_now[POS_SUBQ] = subcode_new_in; // RULE7
    cond_now[POS_CSTAT] = status_buf_changed_in; // RULE8
    cond_now[POS_USER] = user_buf_changed_in; // RULE9
    cond_now[POS_OVF] = overrange_in; // RULE10
    cond_now[POS_RXERR] = |err_now; // RULE11
    for (int i = 0; i < 8; i++) begin
      unique case (trig_code(state_ff.trig_hi, state_ff.trig_lo, i))
        TRIG_RISE: event_hit[i] = cond_now[i] & ~state_ff.cond_prev[i];
        TRIG_FALL: event_hit[i] = ~cond_now[i] & state_ff.cond_prev[i];
        TRIG_LEVEL: event_hit[i] = cond_now[i];
        TRIG_RSVD: event_hit[i] = 1'b0;
      endcase // RULE15
    end
    event_hit = event_hit & state_ff.mask & SRC_VALID; // RULE12 RULE13
    if (state_ff.buf_ctrl[POS_CHSEL]) begin // RULE20
      rx_status_view = {aux_width_b_in, 1'b0, cstat_bits_b_in};
    end else begin
      rx_status_view = {aux_width_a_in, 1'b0, cstat_bits_a_in};
    end
    rx_status_view[3] = state_ff.buf_ctrl[POS_CHSEL] ?
      cstat_bits_b_in[2] : cstat_bits_a_in[2]; // RULE21 RULE22
    rx_status_view[2:0] = state_ff.buf_ctrl[POS_CHSEL] ?
      cstat_bits_b_in : cstat_bits_a_in;
    rx_status_view[7:4] = state_ff.buf_ctrl[POS_CHSEL] ?
      aux_width_b_in : aux_width_a_in;
  end

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    do_write = state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;
    do_read = s_axi_arvalid_in && !state_ff.rvalid;
    wr_idx = reg_index(state_ff.aw_addr);
    rd_idx = reg_index(s_axi_araddr_in);
    wr_byte = state_ff.w_data[7:0];
    // Address and data captured in either order
    if (s_axi_awvalid_in && !state_ff.aw_got) begin
      nxt_state.aw_got = 1'b1;
      nxt_state.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !state_ff.w_got) begin
      nxt_state.w_got = 1'b1;
      nxt_state.w_data = s_axi_wdata_in;
      nxt_state.w_strb = s_axi_wstrb_in;
    end
    if (state_ff.bvalid && s_axi_bready_in) begin
      nxt_state.bvalid = 1'b0;
    end
    if (state_ff.rvalid && s_axi_rready_in) begin
      nxt_state.rvalid = 1'b0;
    end
    // Flags accumulate; masked sources never set them
    nxt_state.flags = state_ff.flags & state_ff.mask; // RULE5
    if (do_write) begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = AXI_OKAY;
      if (state_ff.w_strb[0]) begin
        unique case (wr_idx)
          IDX_ROUTE: nxt_state.route = wr_byte & 8'h77;
          IDX_MASK: nxt_state.mask = wr_byte & SRC_VALID;
          IDX_TRIG_HI: nxt_state.trig_hi = wr_byte & SRC_VALID;
          IDX_TRIG_LO: nxt_state.trig_lo = wr_byte & SRC_VALID;
          IDX_BUF_CTRL: nxt_state.buf_ctrl = wr_byte & 8'h47;
          IDX_ERR_MASK: nxt_state.err_mask = wr_byte & ERR_VALID;
          IDX_PIN_CTRL: nxt_state.pin_pol = wr_byte[1:0];
          IDX_FLAGS, IDX_RX_STATUS, IDX_RX_ERR: ;
          default: nxt_state.bresp = AXI_SLVERR;
        endcase
      end else begin
        unique case (wr_idx)
          IDX_ROUTE, IDX_FLAGS, IDX_MASK, IDX_TRIG_HI, IDX_TRIG_LO,
          IDX_BUF_CTRL, IDX_RX_STATUS, IDX_RX_ERR, IDX_ERR_MASK,
          IDX_PIN_CTRL: ;
          default: nxt_state.bresp = AXI_SLVERR;
        endcase
      end
    end
    if (do_read) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp = AXI_OKAY;
      nxt_state.rdata = 32'h0000_0000;
      unique case (rd_idx)
        IDX_ROUTE: nxt_state.rdata[7:0] = state_ff.route;
        IDX_FLAGS: begin
          nxt_state.rdata[7:0] = state_ff.flags & state_ff.mask; // RULE3
          nxt_state.flags = 8'h00; // RULE4
        end
        IDX_MASK: nxt_state.rdata[7:0] = state_ff.mask;
        IDX_TRIG_HI: nxt_state.rdata[7:0] = state_ff.trig_hi;
        IDX_TRIG_LO: nxt_state.rdata[7:0] = state_ff.trig_lo;
        IDX_BUF_CTRL: nxt_state.rdata[7:0] = state_ff.buf_ctrl;
        IDX_RX_STATUS: nxt_state.rdata[7:0] = rx_status_view;
        IDX_RX_ERR: nxt_state.rdata[7:0] = state_ff.err_reg;
        IDX_ERR_MASK: nxt_state.rdata[7:0] = state_ff.err_mask;
        IDX_PIN_CTRL: nxt_state.rdata[1:0] = state_ff.pin_pol;
        default: nxt_state.rresp = AXI_SLVERR;
      endcase
    end
    // Set after the read-clear so a same-cycle event survives
    nxt_state.flags = nxt_state.flags | event_hit; // RULE25 RULE3
    nxt_state.err_reg = err_now; // RULE24
    nxt_state.cond_prev = cond_now;
    // Pending drives the pin until the status register is read
    nxt_state.pend = (do_read && rd_idx == IDX_FLAGS) ?
      event_hit : (state_ff.pend & state_ff.mask) | event_hit; // RULE12
    irq_active = |nxt_state.pend;
    nxt_state.pass =
      receiver_input_in[state_ff.route[POS_PASS_SEL +: 3]]; // RULE1
    nxt_state.feed =
      receiver_input_in[state_ff.route[POS_RECV_SEL +: 3]]; // RULE2
    unique case (state_ff.pin_pol) // RULE16 RULE23
      POL_HIGH: begin
        nxt_state.irq_o = irq_active;
        nxt_state.irq_oe_n = 1'b0;
      end
      POL_LOW: begin
        nxt_state.irq_o = ~irq_active;
        nxt_state.irq_oe_n = 1'b0;
      end
      POL_OPEN: begin
        nxt_state.irq_o = 1'b0;
        nxt_state.irq_oe_n = ~irq_active;
      end
      default: begin
        nxt_state.irq_o = 1'b0;
        nxt_state.irq_oe_n = 1'b1;
      end
    endcase
  end

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= '0;
      state_ff.route <= RST_ROUTE; // RULE1 RULE2
      state_ff.mask <= RST_MASK; // RULE12
      state_ff.trig_hi <= RST_TRIG;
      state_ff.trig_lo <= RST_TRIG;
      state_ff.buf_ctrl <= RST_BUF_CTRL; // RULE17 RULE18 RULE19
      state_ff.err_mask <= RST_ERR_MASK;
      state_ff.pin_pol <= RST_PIN_POL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign s_axi_awready_out = !state_ff.aw_got;
  assign s_axi_wready_out = !state_ff.w_got;
  assign s_axi_bvalid_out = state_ff.bvalid;
  assign s_axi_bresp_out = state_ff.bresp;
  assign s_axi_arready_out = !state_ff.rvalid;
  assign s_axi_rvalid_out = state_ff.rvalid;
  assign s_axi_rdata_out = state_ff.rdata;
  assign s_axi_rresp_out = state_ff.rresp;
  assign passthru_out = state_ff.pass;
  assign receiver_feed_out = state_ff.feed;
  assign lock_mode_out = state_ff.buf_ctrl[POS_LOCKMODE]; // RULE17
  assign buffer_select_out = state_ff.buf_ctrl[POS_BUFSEL]; // RULE18
  assign buffer_access_mode_out = state_ff.buf_ctrl[POS_ACCESS]; // RULE19
  assign channel_select_out = state_ff.buf_ctrl[POS_CHSEL]; // RULE20
  assign irq_pin_o_out = state_ff.irq_o;
  assign irq_pin_oe_n_out = state_ff.irq_oe_n;
endmodule

// >>> test/rsis_asserts.sv
module rsis_asserts #(
  parameter int NUM_INPUTS = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Routing
  input wire logic [NUM_INPUTS-1:0] receiver_input_in,
  input wire logic passthru_out,
  input wire logic receiver_feed_out,
  // Register reads
  input wire logic [9:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  // Channel status and configuration
  input wire logic [3:0] aux_width_a_in,
  input wire logic [3:0] aux_width_b_in,
  input wire logic [2:0] cstat_bits_a_in,
  input wire logic [2:0] cstat_bits_b_in,
  input wire logic channel_select_out,
  input wire logic lock_mode_out,
  input wire logic buffer_select_out,
  input wire logic buffer_access_mode_out,
  input wire logic irq_pin_o_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_status_read;
    s_axi_arvalid_in && !s_axi_rvalid_out && s_axi_araddr_in == 10'h094;
  endsequence

  property p_pass_high;
    receiver_input_in == '1 |=> passthru_out;
  endproperty
  property p_feed_low;
    receiver_input_in == '0 |=> !receiver_feed_out;
  endproperty
  property p_lock_rst;
    $rose(rst_n_in) |-> lock_mode_out;
  endproperty
  property p_buffer_select_rst;
    $rose(rst_n_in) |-> !buffer_select_out;
  endproperty
  property p_cam_rst;
    $rose(rst_n_in) |-> !buffer_access_mode_out;
  endproperty
  property p_irq_rst;
    $rose(rst_n_in) |-> !irq_pin_o_out;
  endproperty
  property p_aux_a;
    s_status_read ##0 !channel_select_out
      |=> s_axi_rdata_out[7:4] == $past(aux_width_a_in);
  endproperty
  property p_fmt_a;
    s_status_read ##0 !channel_select_out
      |=> s_axi_rdata_out[3] == $past(cstat_bits_a_in[2]);
  endproperty
  property p_chan_b;
    s_status_read ##0 channel_select_out |=> s_axi_rdata_out[7:0] ==
      {$past(aux_width_b_in), $past(cstat_bits_b_in[2]),
       $past(cstat_bits_b_in)};
  endproperty

  a_pass_high: assert property (p_pass_high)
    else $error("pass-through output not high");
  a_feed_low: assert property (p_feed_low)
    else $error("receiver feed not low");
  a_lock_rst: assert property (p_lock_rst)
    else $error("lock mode not set after reset");
  a_buffer_select_rst: assert property (p_buffer_select_rst)
    else $error("buffer select not clear after reset");
  a_cam_rst: assert property (p_cam_rst)
    else $error("access mode not clear after reset");
  a_irq_rst: assert property (p_irq_rst)
    else $error("interrupt pin active after reset");
  a_aux_a: assert property (p_aux_a)
    else $error("aux width of channel A wrong");
  a_fmt_a: assert property (p_fmt_a)
    else $error("format bit of channel A wrong");
  a_chan_b: assert property (p_chan_b)
    else $error("channel B status wrong");
endmodule

bind rsis_top rsis_asserts #(.NUM_INPUTS(NUM_INPUTS)) u_chk (.*);

// >>> test/rsis_host.sv
module rsis_host (
  // Clock
  input wire logic clk_sys_in,
  // Write channels
  output logic [9:0] s_axi_awaddr_in,
  output logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  output logic [31:0] s_axi_wdata_in,
  output logic [3:0] s_axi_wstrb_in,
  output logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic [1:0] s_axi_bresp_out,
  output logic s_axi_bready_in,
  // Read channels
  output logic [9:0] s_axi_araddr_in,
  output logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  output logic s_axi_rready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] bresp_seen;
  initial begin
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
    {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
    {s_axi_awaddr_in, s_axi_araddr_in} = 20'h0_0000;
    s_axi_wdata_in = 32'h0000_0000;
    s_axi_wstrb_in = 4'hf;
  end
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h00_0000, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out);
    bresp_seen = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out);
    d = s_axi_rdata_out[7:0];
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask
endmodule

// >>> test/rsis_top_bench.sv
module rsis_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rsis_pkg::*;
  logic clk_sys_in, rst_n_in, s_axi_awvalid_in, s_axi_awready_out;
  logic s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic s_axi_rvalid_out, s_axi_rready_in, passthru_out;
  logic receiver_feed_out, lock_mode_out, buffer_select_out;
  logic buffer_access_mode_out, channel_select_out;
  logic irq_pin_o_out, irq_pin_oe_n_out;
  logic [9:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
  logic [7:0] receiver_input_in, ev, d;
  logic [3:0] aux_width_a_in = 4'h8;
  logic [3:0] aux_width_b_in = 4'h3;
  logic [2:0] cstat_bits_a_in = 3'h5;
  logic [2:0] cstat_bits_b_in = 3'h2;
  wire lock_lost_in = ev[POS_LOCK];
  wire subcode_new_in = ev[POS_SUBQ];
  wire status_buf_changed_in = ev[POS_CSTAT];
  wire user_buf_changed_in = ev[POS_USER];
  wire overrange_in = ev[POS_OVF];
  wire [6:0] rx_error_cause_in = {6'h00, ev[POS_RXERR]};
  wire [7:0] cfg_view = {4'h0, lock_mode_out, buffer_select_out,
    buffer_access_mode_out, channel_select_out};
  int errors = 0;
  int samples_checked = 0;
  // Route, inputs, expected {pass, feed}
  logic [23:0] rows [8] = '{24'h07_0102, 24'h16_0202, 24'h25_0402,
    24'h34_1803, 24'h43_0801, 24'h52_2002, 24'h61_bd00, 24'h70_8002};
  logic [15:0] rst_tab [7] = '{{IDX_ROUTE, RST_ROUTE}, {IDX_FLAGS, 8'h00},
    {IDX_MASK, RST_MASK}, {IDX_TRIG_HI, RST_TRIG}, {IDX_TRIG_LO, RST_TRIG},
    {IDX_BUF_CTRL, RST_BUF_CTRL}, {IDX_PIN_CTRL, 6'h00, RST_PIN_POL}};

  rsis_top dut (.*);
  rsis_host host (.*);

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic flags(input logic [7:0] e, input int w);
    repeat (w) @(posedge clk_sys_in);
    host.rd({IDX_FLAGS, 2'b00}, d, r);
    chk("flags", e, d);
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
  initial begin
    rst_n_in = 1'b0;
    receiver_input_in = 8'h00;
    ev = 8'h00;
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    foreach (rst_tab[i]) begin
      host.rd({rst_tab[i][15:8], 2'b00}, d, r);
      chk("reset value", rst_tab[i][7:0], d);
      chk("reset resp", {6'h00, AXI_OKAY}, {6'h00, r});
    end
    foreach (rows[i]) begin
      host.wr({IDX_ROUTE, 2'b00}, rows[i][23:16]);
      receiver_input_in <= rows[i][15:8];
      repeat (2) @(posedge clk_sys_in);
      chk("pass", {7'h00, rows[i][1]}, {7'h00, passthru_out});
      chk("feed", {7'h00, rows[i][0]}, {7'h00, receiver_feed_out});
    end
    receiver_input_in <= 8'hff;
    repeat (2) @(posedge clk_sys_in);
    chk("pass all", 8'h01, {7'h00, passthru_out});
    chk("feed all", 8'h01, {7'h00, receiver_feed_out});
    receiver_input_in <= 8'h00;
    host.wr({IDX_ERR_MASK, 2'b00}, 8'h01);
    host.wr({IDX_MASK, 2'b00}, SRC_VALID);
    for (int i = 0; i < 8; i++) if (SRC_VALID[i]) begin
      ev <= 8'(8'h01 << i);
      @(posedge clk_sys_in);
      ev <= 8'h00;
      repeat (2) @(posedge clk_sys_in);
      chk("pin", 8'h01, {7'h00, irq_pin_o_out});
      flags(8'(8'h01 << i), 0);
      flags(8'h00, 0);
      chk("pin off", 8'h00, {7'h00, irq_pin_o_out});
    end
    host.wr({IDX_MASK, 2'b00}, 8'h80);
    ev <= 8'h02;
    flags(8'h00, 2);
    chk("masked pin", 8'h00, {7'h00, irq_pin_o_out});
    host.wr({IDX_TRIG_LO, 2'b00}, 8'h80);
    ev <= 8'h80;
    flags(8'h00, 3);
    ev <= 8'h00;
    flags(8'h80, 3);
    host.wr({IDX_TRIG_LO, 2'b00}, 8'h00);
    host.wr({IDX_TRIG_HI, 2'b00}, 8'h80);
    ev <= 8'h80;
    flags(8'h80, 3);
    flags(8'h80, 1);
    host.wr({IDX_PIN_CTRL, 2'b00}, 8'h01);
    repeat (2) @(posedge clk_sys_in);
    chk("low pin", 8'h00, {7'h00, irq_pin_o_out});
    chk("low pin drive", 8'h00, {7'h00, irq_pin_oe_n_out});
    host.wr({IDX_TRIG_LO, 2'b00}, 8'h80);
    flags(8'h80, 0);
    flags(8'h00, 2);
    ev <= 8'h00;
    flags(8'h00, 2);
    chk("low pin idle", 8'h01, {7'h00, irq_pin_o_out});
    host.wr({IDX_PIN_CTRL, 2'b00}, 8'h02);
    repeat (2) @(posedge clk_sys_in);
    chk("drain pin", 8'h01, {7'h00, irq_pin_oe_n_out});
    for (int c = 0; c < 2; c++) begin
      host.wr({IDX_BUF_CTRL, 2'b00}, 8'(8'h40 + c));
      host.rd({IDX_RX_STATUS, 2'b00}, d, r);
      chk("status", c ? 8'h32 : 8'h8d, d);
    end
    host.wr({IDX_BUF_CTRL, 2'b00}, 8'h06);
    chk("write resp", {6'h00, AXI_OKAY}, {6'h00, host.bresp_seen});
    chk("buffer ctrl", 8'h06, cfg_view);
    host.wr(10'h3fc, 8'h00);
    chk("write resp", {6'h00, AXI_SLVERR}, {6'h00, host.bresp_seen});
    host.rd(10'h3fc, d, r);
    chk("resp", {6'h00, AXI_SLVERR}, {6'h00, r});
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    chk("reset again", 8'h08, cfg_view);
    report_and_stop();
  end
endmodule
